// file: logic/amp_protection_sequencer.sv
// Purpose: Protection and start-up sequencing of a two-channel
//          class-D amplifier controller.
// Assumes: All inputs synchronous to clk; analog pins as 25 mV codes.
// Notes:   Timers count switching oscillator periods.
`timescale 1ns/10ps
`default_nettype none
`include "amp_seq_regs.svh"

module amp_protection_sequencer #(
   parameter int unsigned DWELL_TICKS = `T_DWELL_MS * `F_OSC_NOM_KHZ,
   parameter int unsigned RETRY_TICKS = `T_RETRY_MS * `F_OSC_NOM_KHZ
) (
   input  wire logic                     clk,
   input  wire logic                     nrst,
   input  wire logic [7:0]               mode_level,
   input  wire logic [7:0]               osc_level,
   input  wire logic                     ext_clk_in,
   input  wire logic [9:0]               osc_divisor,
   input  wire logic                     overcurrent_fault_in,
   input  wire logic                     overtemp_fault_in,
   input  wire amp_seq_pkg::feedback_t   output_feedback_ch1,
   input  wire amp_seq_pkg::feedback_t   output_feedback_ch2,
   input  wire logic                     clip_active,
   output logic                          stage_enable_ch1,
   output logic                          stage_enable_ch2,
   output logic                          audio_mute,
   output logic                          ext_osc_select,
   output logic                          ext_freq_ok,
   output logic                          short_detected,
   output logic [5:0]                    min_pulse_cycles,
   output amp_seq_pkg::seq_state_t       seq_state
);

   localparam logic [7:0] OSC_TRIP = 8'(`OSC_TRIP_MV / `MODE_LSB_MV);
   localparam logic [9:0] DIV_MIN  =
      10'((`CLK_KHZ + `F_INT_MAX_KHZ - 1) / `F_INT_MAX_KHZ);
   localparam logic [9:0] DIV_MAX  = 10'(`CLK_KHZ / `F_INT_MIN_KHZ);
   localparam logic [9:0] EXT_PMIN =
      10'((`CLK_KHZ + `F_EXT_MAX_KHZ - 1) / `F_EXT_MAX_KHZ);
   localparam logic [9:0] EXT_PMAX = 10'(`CLK_KHZ / `F_EXT_MIN_KHZ);
   localparam logic [5:0] MINPW    = 6'(`T_MINPW_NS / `CLK_PERIOD_NS);
   localparam logic [23:0] DWELL_LAST = 24'(DWELL_TICKS - 1);
   localparam logic [23:0] RETRY_LAST = 24'(RETRY_TICKS - 1);

   logic                     rst_meta_reg;
   logic                     rst_n;
   amp_seq_pkg::mode_t       mode;
   amp_seq_pkg::seq_state_t  st_reg;
   amp_seq_pkg::seq_state_t  st_next;
   logic [23:0]              tmr_reg;
   logic [9:0]               div_reg;
   logic [9:0]               period_reg;
   logic                     ext_prev_reg;
   logic                     ext_rise;
   logic                     int_tick;
   logic                     osc_tick;
   logic                     short_now;
   logic                     dwell_done;
   logic                     retry_done;
   logic                     en_next;
   logic                     check_ok_reg;

   // Clamp divisor to the supported internal range
   function automatic logic [9:0] clamp_div(input logic [9:0] d);
      if (d < DIV_MIN) begin
         clamp_div = DIV_MIN;
      end else if (d > DIV_MAX) begin
         clamp_div = DIV_MAX;
      end else begin
         clamp_div = d;
      end
   endfunction : clamp_div

   // Run states drive the power stage enables
   function automatic logic is_run(input amp_seq_pkg::seq_state_t s);
      is_run = (s == amp_seq_pkg::ST_MUTE) || (s == amp_seq_pkg::ST_DWELL)
               || (s == amp_seq_pkg::ST_ON);
   endfunction : is_run

   // Reset release synchroniser
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   mode_decoder u_mode (
      .clk        (clk),
      .rst_n      (rst_n),
      .mode_level (mode_level),
      .mode       (mode)
   );

   // External clock selection by trip level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_osc_select <= 1'b0;
      end else begin
         ext_osc_select <= (osc_level > OSC_TRIP);
      end
   end

   // Internal oscillator divider
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_reg <= 10'h000;
      end else if (int_tick || ext_osc_select) begin
         div_reg <= 10'h000;
      end else begin
         div_reg <= div_reg + 10'h001;
      end
   end
   assign int_tick = (div_reg >= clamp_div(osc_divisor) - 10'h001);

   // External edge detect and period check
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_prev_reg <= 1'b0;
         period_reg   <= 10'h000;
         ext_freq_ok  <= 1'b0;
      end else begin
         ext_prev_reg <= ext_clk_in;
         if (ext_rise) begin
            period_reg  <= 10'h001;
            ext_freq_ok <= (period_reg >= EXT_PMIN)
                           && (period_reg <= EXT_PMAX);
         end else if (period_reg > EXT_PMAX) begin
            ext_freq_ok <= 1'b0;
         end else begin
            period_reg <= period_reg + 10'h001;
         end
      end
   end
   assign ext_rise = ext_clk_in && !ext_prev_reg;

   // Active switching oscillator period
   assign osc_tick = ext_osc_select ? ext_rise : int_tick;

   // Combined short detection of both feedback lines
   assign short_now = (|output_feedback_ch1) || (|output_feedback_ch2);
   assign dwell_done = osc_tick && (tmr_reg >= DWELL_LAST);
   assign retry_done = osc_tick && (tmr_reg >= RETRY_LAST);

   // Sequencer next state
   always_comb begin
      st_next = st_reg;
      case (st_reg)
         amp_seq_pkg::ST_STANDBY: begin
            if (mode != amp_seq_pkg::MODE_STANDBY) begin
               st_next = amp_seq_pkg::ST_CHECK;
            end
         end
         amp_seq_pkg::ST_CHECK: begin
            if (mode == amp_seq_pkg::MODE_STANDBY) begin
               st_next = amp_seq_pkg::ST_STANDBY;
            end else if (!short_now) begin
               st_next = amp_seq_pkg::ST_MUTE;
            end
         end
         amp_seq_pkg::ST_MUTE, amp_seq_pkg::ST_DWELL,
         amp_seq_pkg::ST_ON: begin
            if (mode == amp_seq_pkg::MODE_STANDBY) begin
               st_next = amp_seq_pkg::ST_STANDBY;
            end else if (!overcurrent_fault_in) begin
               st_next = amp_seq_pkg::ST_OC_WAIT;
            end else if (mode == amp_seq_pkg::MODE_MUTE) begin
               st_next = amp_seq_pkg::ST_MUTE;
            end else if (st_reg == amp_seq_pkg::ST_MUTE) begin
               st_next = amp_seq_pkg::ST_DWELL;
            end else if (st_reg == amp_seq_pkg::ST_DWELL && dwell_done) begin
               st_next = amp_seq_pkg::ST_ON;
            end
         end
         amp_seq_pkg::ST_OC_WAIT: begin
            if (mode == amp_seq_pkg::MODE_STANDBY) begin
               st_next = amp_seq_pkg::ST_STANDBY;
            end else if (retry_done) begin
               st_next = amp_seq_pkg::ST_CHECK;
            end
         end
         default: begin
            st_next = amp_seq_pkg::ST_STANDBY;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= amp_seq_pkg::ST_STANDBY;
      end else begin
         st_reg <= st_next;
      end
   end

   // Oscillator period timer, restarted on state change
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tmr_reg <= 24'h000000;
      end else if (st_next != st_reg) begin
         tmr_reg <= 24'h000000;
      end else if (osc_tick) begin
         tmr_reg <= tmr_reg + 24'h000001;
      end
   end

   // Enables gated by both diagnostics
   assign en_next = is_run(st_next) && overcurrent_fault_in
                    && overtemp_fault_in;

   // Registered outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage_enable_ch1 <= 1'b0;
         stage_enable_ch2 <= 1'b0;
         audio_mute       <= 1'b1;
         seq_state        <= amp_seq_pkg::ST_STANDBY;
      end else begin
         stage_enable_ch1 <= en_next;
         stage_enable_ch2 <= en_next;
         audio_mute       <= (st_next != amp_seq_pkg::ST_ON);
         seq_state        <= st_next;
      end
   end

   // Short flag, evaluated only during the check
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         short_detected <= 1'b0;
      end else if (st_reg == amp_seq_pkg::ST_CHECK) begin
         short_detected <= short_now;
      end else if (st_reg == amp_seq_pkg::ST_STANDBY) begin
         short_detected <= 1'b0;
      end
   end

   // Effective minimum pulse, halved while clipping
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         min_pulse_cycles <= MINPW;
      end else begin
         min_pulse_cycles <= clip_active ? (MINPW >> 1) : MINPW;
      end
   end

   // Remembers a passed check until the run ends
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         check_ok_reg <= 1'b0;
      end else if (st_reg == amp_seq_pkg::ST_CHECK && !short_now) begin
         check_ok_reg <= 1'b1;
      end else if (!is_run(st_reg) && st_reg != amp_seq_pkg::ST_CHECK) begin
         check_ok_reg <= 1'b0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_oc_enable_off: assert property (
      !overcurrent_fault_in |=> !stage_enable_ch1 && !stage_enable_ch2)
      else $error("enables not dropped on overcurrent");
   a_oc_retry_time: assert property (
      (st_reg == amp_seq_pkg::ST_OC_WAIT && retry_done
       && mode != amp_seq_pkg::MODE_STANDBY)
      |=> st_reg == amp_seq_pkg::ST_CHECK)
      else $error("retry not started after interval");
   a_oc_wait_hold: assert property (
      (st_reg == amp_seq_pkg::ST_OC_WAIT && !retry_done)
      |=> !stage_enable_ch1 && !stage_enable_ch2)
      else $error("enable during retry wait");
   a_check_entry: assert property (
      (st_reg == amp_seq_pkg::ST_STANDBY
       && mode == amp_seq_pkg::MODE_MUTE)
      |=> st_reg == amp_seq_pkg::ST_CHECK)
      else $error("check not started from standby");
   a_check_blocks: assert property (
      (st_reg == amp_seq_pkg::ST_CHECK && short_now
       && mode != amp_seq_pkg::MODE_STANDBY)
      |=> st_reg == amp_seq_pkg::ST_CHECK && short_detected)
      else $error("start-up continued with shorted output");
   a_enable_checked: assert property (
      $rose(stage_enable_ch1) |-> $past(check_ok_reg) || check_ok_reg)
      else $error("enable raised without passed check");
   a_short_ignored: assert property (
      (is_run(st_reg) && short_now
       && mode != amp_seq_pkg::MODE_STANDBY && overcurrent_fault_in)
      |=> is_run(st_reg))
      else $error("short check acted in normal operation");
   a_ot_enable_off: assert property (
      !overtemp_fault_in |=> !stage_enable_ch1 && !stage_enable_ch2)
      else $error("enables not dropped on overtemperature");
   a_ot_release: assert property (
      ($rose(overtemp_fault_in) && overcurrent_fault_in
       && is_run(st_reg) && mode != amp_seq_pkg::MODE_STANDBY)
      |=> stage_enable_ch1 && stage_enable_ch2)
      else $error("enables not restored after overtemperature");
   a_dwell_wait: assert property (
      (st_reg == amp_seq_pkg::ST_DWELL && !dwell_done)
      |=> st_reg != amp_seq_pkg::ST_ON && audio_mute)
      else $error("on entered before mute dwell");
   a_ext_select: assert property (
      (osc_level > OSC_TRIP) [*2] |-> ext_osc_select)
      else $error("external clock not selected");
   a_min_pulse: assert property (
      clip_active |=> min_pulse_cycles == (MINPW >> 1))
      else $error("minimum pulse not halved in clipping");

   c_reach_on: cover property (
      st_reg == amp_seq_pkg::ST_DWELL ##1 st_reg == amp_seq_pkg::ST_ON);
   c_oc_retry: cover property (
      st_reg == amp_seq_pkg::ST_OC_WAIT ##1 st_reg == amp_seq_pkg::ST_CHECK);
   c_check_blocked: cover property (
      st_reg == amp_seq_pkg::ST_CHECK && short_now [*3]);
   c_ext_clock: cover property (ext_osc_select && ext_freq_ok);

endmodule : amp_protection_sequencer
`default_nettype wire

// file: logic/amp_seq_regs.svh
// Purpose: Named constants of the amplifier protection sequencer.
// Assumes: 200 MHz system clock; analog levels arrive as 25 mV codes.
// Notes:   Definitions only.
`ifndef AMP_SEQ_REGS_SVH
`define AMP_SEQ_REGS_SVH

// Clock
`define CLK_PERIOD_NS   5
`define CLK_KHZ         200000

// Mode input thresholds, codes of 25 mV (1.6 V, 1.0 V, 3.8 V, 3.2 V)
`define MODE_LSB_MV     25
`define MODE_TH1_UP_MV  1600
`define MODE_TH1_DN_MV  1000
`define MODE_TH2_UP_MV  3800
`define MODE_TH2_DN_MV  3200

// Oscillator pin trip level above signal ground (2.5 V)
`define OSC_TRIP_MV     2500

// Switching frequency ranges in kHz
`define F_INT_MIN_KHZ   210
`define F_INT_MAX_KHZ   600
`define F_EXT_MIN_KHZ   200
`define F_EXT_MAX_KHZ   600
`define F_OSC_NOM_KHZ   317

// Mute dwell and overcurrent retry interval
`define T_DWELL_MS      220
`define T_RETRY_MS      220

// Power stage minimum pulse width
`define T_MINPW_NS      220

`endif

// file: logic/amp_seq_pkg.sv
// Purpose: Types shared by the amplifier protection sequencer.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes:   Constants live in amp_seq_regs.svh.
package amp_seq_pkg;

   // Decoded mode input
   typedef enum logic [1:0] {
      MODE_STANDBY = 2'b00,
      MODE_MUTE    = 2'b01,
      MODE_ON      = 2'b10
   } mode_t;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_STANDBY = 3'b000,
      ST_CHECK   = 3'b001,
      ST_MUTE    = 3'b010,
      ST_DWELL   = 3'b011,
      ST_ON      = 3'b100,
      ST_OC_WAIT = 3'b101
   } seq_state_t;

   // Rail comparators on one output feedback line
   typedef struct packed {
      logic to_supply;   // Line stuck at positive rail
      logic to_ground;   // Line stuck at negative rail
   } feedback_t;

endpackage : amp_seq_pkg

// file: logic/mode_decoder.sv
// Purpose: Three-level mode input decode with hysteresis.
// Assumes: mode_level is a synchronous 25 mV code of the mode pin.
// Notes:   Two independent hysteresis comparators.
`timescale 1ns/10ps
`default_nettype none
`include "amp_seq_regs.svh"

module mode_decoder (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic [7:0]           mode_level,
   output var  amp_seq_pkg::mode_t   mode
);

   localparam logic [7:0] TH1_UP = 8'(`MODE_TH1_UP_MV / `MODE_LSB_MV);
   localparam logic [7:0] TH1_DN = 8'(`MODE_TH1_DN_MV / `MODE_LSB_MV);
   localparam logic [7:0] TH2_UP = 8'(`MODE_TH2_UP_MV / `MODE_LSB_MV);
   localparam logic [7:0] TH2_DN = 8'(`MODE_TH2_DN_MV / `MODE_LSB_MV);

   logic above1_reg;
   logic above2_reg;

   // Standby/mute comparator
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         above1_reg <= 1'b0;
      end else if (mode_level > TH1_UP) begin
         above1_reg <= 1'b1;
      end else if (mode_level < TH1_DN) begin
         above1_reg <= 1'b0;
      end
   end

   // Mute/on comparator
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         above2_reg <= 1'b0;
      end else if (mode_level > TH2_UP) begin
         above2_reg <= 1'b1;
      end else if (mode_level < TH2_DN) begin
         above2_reg <= 1'b0;
      end
   end

   // Registered decode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode <= amp_seq_pkg::MODE_STANDBY;
      end else if (above2_reg) begin
         mode <= amp_seq_pkg::MODE_ON;
      end else if (above1_reg) begin
         mode <= amp_seq_pkg::MODE_MUTE;
      end else begin
         mode <= amp_seq_pkg::MODE_STANDBY;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_hyst_low_hold: assert property (
      (!above1_reg && mode_level <= TH1_UP) |=> !above1_reg)
      else $error("standby left inside hysteresis band");
   a_hyst_high_hold: assert property (
      (above2_reg && mode_level >= TH2_DN) |=> above2_reg)
      else $error("on dropped inside hysteresis band");
   a_mode_on_decode: assert property (
      (mode_level > TH2_UP) |=> ##1 (mode == amp_seq_pkg::MODE_ON))
      else $error("high level not decoded as on");

endmodule : mode_decoder
`default_nettype wire

// file: tb/power_stage_model.sv
// Purpose: Behavioural power stage facing the protection sequencer.
// Assumes: Diagnostic outputs are open drain with pull-ups.
// Notes:   Bench commands a load short, heat or a rail short.
`timescale 1ns/10ps
`default_nettype none

module power_stage_model (
   input  wire logic                 clk,
   input  wire logic                 en1,
   input  wire logic                 en2,
   input  wire logic                 load_short,
   input  wire logic                 hot,
   input  wire logic [3:0]           rail_short,
   output var  logic                 fault_cur_n,
   output var  logic                 fault_tmp_n,
   output var  amp_seq_pkg::feedback_t fb1,
   output var  amp_seq_pkg::feedback_t fb2
);
   initial fault_cur_n = 1'b1;

   // Limit seen only while driving a shorted load; pull-up otherwise
   always @(posedge clk) begin
      #1;
      fault_cur_n <= !(load_short && (en1 || en2));
   end

   // Heat report and rail comparators follow the bench commands
   always_comb begin
      fault_tmp_n = !hot;
      fb1         = rail_short[3:2];
      fb2         = rail_short[1:0];
   end
endmodule : power_stage_model

`default_nettype wire

// file: tb/amp_protection_sequencer_test.sv
// Purpose: Self-checking bench of the protection sequencer.
// Assumes: Timers shortened to 20 ticks, internal tick every 334 clk.
// Notes:   Inputs change 1 ns after the rising edge.
`timescale 1ns/10ps
`default_nettype none

module amp_protection_sequencer_test;
   localparam int TICKS = 20;
   localparam int DIV   = 334;
   logic       clk = 1'b0;
   logic       nrst = 1'b0;
   logic [7:0] mode_level = 8'h00;
   logic [7:0] osc_level = 8'h00;
   logic       clip_active = 1'b0;
   logic       load_short = 1'b0;
   logic       hot = 1'b0;
   logic [3:0] rail_short = 4'h0;
   logic       ext_clk = 1'b0;
   logic       ext_ok;
   logic [9:0] osc_div = 10'd334;
   logic       oc_n, ot_n, en1, en2, amute, ext_sel, short_det;
   logic [5:0] min_pw;
   amp_seq_pkg::feedback_t    fb1, fb2;
   amp_seq_pkg::seq_state_t   st;
   int errors = 0;
   int total_checks = 0;

   always #2.5 clk = ~clk;

   amp_protection_sequencer #(.DWELL_TICKS(TICKS), .RETRY_TICKS(TICKS))
   i_amp_protection_sequencer (
      .clk(clk), .nrst(nrst), .mode_level(mode_level),
      .osc_level(osc_level), .ext_clk_in(ext_clk), .osc_divisor(osc_div),
      .overcurrent_fault_in(oc_n), .overtemp_fault_in(ot_n),
      .output_feedback_ch1(fb1), .output_feedback_ch2(fb2),
      .clip_active(clip_active), .stage_enable_ch1(en1),
      .stage_enable_ch2(en2), .audio_mute(amute),
      .ext_osc_select(ext_sel), .ext_freq_ok(ext_ok),
      .short_detected(short_det), .min_pulse_cycles(min_pw),
      .seq_state(st));

   power_stage_model i_power_stage_model (
      .clk(clk), .en1(en1), .en2(en2), .load_short(load_short),
      .hot(hot), .rail_short(rail_short), .fault_cur_n(oc_n),
      .fault_tmp_n(ot_n), .fb1(fb1), .fb2(fb2));

   // Verdict and end of run
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_sim

   task automatic step(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask : step

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_st(input amp_seq_pkg::seq_state_t exp);
      chk({5'h00, st}, {5'h00, exp});
   endtask : chk_st

   // Bounded wait for a state; running out counts a mismatch
   task automatic wait_st(input amp_seq_pkg::seq_state_t exp,
                          input int n);
      int i;
      for (i = 0; i < n && st !== exp; i++)
         step(1);
      chk_st(exp);
      if (st !== exp)
         end_sim();
   endtask : wait_st

   // External oscillator on the frequency pin, half period in clk cycles
   task automatic ext_run(input int half, input int n);
      repeat (n) begin
         ext_clk = 1'b1;
         step(half);
         ext_clk = 1'b0;
         step(half);
      end
   endtask : ext_run

   task automatic en(input logic [1:0] exp);
      chk({6'h00, en1, en2}, {6'h00, exp});
   endtask : en

   initial begin
      step(4);
      nrst = 1'b1;
      step(3);
      chk_st(amp_seq_pkg::ST_STANDBY);
      en(2'b00);
      chk({7'h00, amute}, 8'h01);
      chk({2'h0, min_pw}, 8'h2c);
      $display("test reset done");
      // Shorted output holds the start-up check
      rail_short = 4'h8;
      mode_level = 8'h50;
      wait_st(amp_seq_pkg::ST_CHECK, 8);
      step(10);
      chk_st(amp_seq_pkg::ST_CHECK);
      en(2'b00);
      chk({7'h00, short_det}, 8'h01);
      rail_short = 4'h0;
      wait_st(amp_seq_pkg::ST_MUTE, 4);
      en(2'b11);
      $display("test startup done");
      // Short ignored once running; hysteresis holds levels
      rail_short = 4'h5;
      step(6);
      chk_st(amp_seq_pkg::ST_MUTE);
      en(2'b11);
      rail_short = 4'h0;
      mode_level = 8'h32;
      step(6);
      chk_st(amp_seq_pkg::ST_MUTE);
      mode_level = 8'h97;
      step(6);
      chk_st(amp_seq_pkg::ST_MUTE);
      $display("test hold done");
      // Mute dwell before on
      mode_level = 8'ha0;
      wait_st(amp_seq_pkg::ST_DWELL, 8);
      step((TICKS - 1) * DIV - 5);
      chk_st(amp_seq_pkg::ST_DWELL);
      chk({7'h00, amute}, 8'h01);
      wait_st(amp_seq_pkg::ST_ON, DIV + 10);
      chk({7'h00, amute}, 8'h00);
      mode_level = 8'h82;
      step(6);
      chk_st(amp_seq_pkg::ST_ON);
      mode_level = 8'h7f;
      wait_st(amp_seq_pkg::ST_MUTE, 8);
      $display("test dwell done");
      // Overtemperature gates enables both ways
      hot = 1'b1;
      step(2);
      en(2'b00);
      chk_st(amp_seq_pkg::ST_MUTE);
      hot = 1'b0;
      step(2);
      en(2'b11);
      $display("test temp done");
      // Overcurrent shutdown, retry, persisting short
      osc_div = 10'd100;
      load_short = 1'b1;
      wait_st(amp_seq_pkg::ST_OC_WAIT, 4);
      en(2'b00);
      step((TICKS - 1) * DIV - 5);
      chk_st(amp_seq_pkg::ST_OC_WAIT);
      wait_st(amp_seq_pkg::ST_CHECK, DIV + 10);
      wait_st(amp_seq_pkg::ST_MUTE, 3);
      en(2'b11);
      wait_st(amp_seq_pkg::ST_OC_WAIT, 4);
      en(2'b00);
      load_short = 1'b0;
      wait_st(amp_seq_pkg::ST_CHECK, TICKS * DIV + 10);
      wait_st(amp_seq_pkg::ST_MUTE, 3);
      step(4);
      en(2'b11);
      $display("test overcurrent done");
      // Oscillator trip level and clipping pulse width
      osc_level = 8'h65;
      step(3);
      chk({7'h00, ext_sel}, 8'h01);
      ext_run(200, 2);
      chk({7'h00, ext_ok}, 8'h01);
      ext_run(100, 2);
      chk({7'h00, ext_ok}, 8'h00);
      osc_level = 8'h64;
      step(3);
      chk({7'h00, ext_sel}, 8'h00);
      clip_active = 1'b1;
      step(3);
      chk({2'h0, min_pw}, 8'h16);
      clip_active = 1'b0;
      step(3);
      chk({2'h0, min_pw}, 8'h2c);
      step(10 * DIV);
      mode_level = 8'h27;
      wait_st(amp_seq_pkg::ST_STANDBY, 8);
      en(2'b00);
      $display("test osc and standby done");
      end_sim();
   end
endmodule : amp_protection_sequencer_test

`default_nettype wire
